// ### rtl/rxetg_top.sv
// rxetg_top: receiver event trigger modes, sticky status, interrupt and output-one select
// Functional notes
// - mode field: 00 rising (reset), 01 falling, 10 level, 11 reserved
// - mode register three holds only slip mode in bits 1:0; rest read zero
// - select register bits 3:0 pick output-one source; bits 7:4 read zero
// - code 0000 forces output low (reset default), 0001 forces it high
// - code 0010 drives the converter interrupt, inverted, low while asserted
// - code 0011 drives the transmitter interrupt, low while asserted
// - code 0100 drives the receiver interrupt, low while any enabled sticky status bit is set
// - the pin is registered and follows the selected fixed state or live source one clock later
//
// The AXI4-Lite slave port was left to the implementer.
module rxetg_top
	import rxetg_pkg::*;
(
	input wire logic aclk, // system clock, 250 MHz
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [RXETG_ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [RXETG_ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [RXETG_NUM_EV-1:0] rx_event_flag, // raw receiver event flags
	input wire logic src_irq, // converter interrupt, active high
	input wire logic tx_irq, // transmitter interrupt, active high
	output logic rx_irq, // receiver interrupt, active high level
	output logic general_output_pin_one // first general-purpose output
);
	typedef struct packed {
		logic aw_held;
		logic [RXETG_ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] buffer_transfer_trigger_mode;
		logic [1:0] status_crc_error_trigger_mode;
		logic [1:0] parity_error_trigger_mode;
		logic [1:0] validity_error_trigger_mode;
		logic [1:0] biphase_error_trigger_mode;
		logic [1:0] output_slip_trigger_mode;
		logic [3:0] output_one_source_select;
		logic [RXETG_NUM_EV-1:0] status;
		logic [RXETG_NUM_EV-1:0] mask;
		logic irq;
		logic pin;
	} rxetg_state_t;

	rxetg_state_t state;
	rxetg_state_t next_state;
	rxetg_trig_if #(.NUM_EV(RXETG_NUM_EV)) trig ();
	logic [RXETG_NUM_EV-1:0] clr_mask;
	logic [RXETG_NUM_EV-1:0] next_status;

	// word index of a byte address; unaligned low bits are ignored
	function automatic logic [7:0] rxetg_index(input logic [RXETG_ADDR_W-1:0] addr);
		rxetg_index = addr[RXETG_ADDR_W-1:2];
	endfunction : rxetg_index

	// true when the index names a register of this block
	function automatic logic rxetg_mapped(input logic [7:0] idx);
		rxetg_mapped = (idx == RXETG_IDX_MODE_TWO) || (idx == RXETG_IDX_MODE_THREE) ||
			(idx == RXETG_IDX_GPO_SEL) || (idx == RXETG_IDX_MODE_ONE) ||
			(idx == RXETG_IDX_STATUS) || (idx == RXETG_IDX_MASK);
	endfunction : rxetg_mapped

	////////////////////////////////////////////////////////////////////////
	// trigger detection per event
	assign trig.flag = rx_event_flag;
	assign trig.mode = {state.output_slip_trigger_mode, state.biphase_error_trigger_mode,
		state.validity_error_trigger_mode, state.parity_error_trigger_mode,
		state.status_crc_error_trigger_mode, state.buffer_transfer_trigger_mode};
	rxetg_detect u_detect (
		.aclk(aclk),
		.aresetn(aresetn),
		.trig(trig)
	);

	////////////////////////////////////////////////////////////////////////
	// register file, bus slave, status and pin select
	always_comb begin
		logic aw_ok;
		logic [7:0] widx;
		logic [7:0] ridx;
		logic [31:0] rd;
		aw_ok = 1'b0;
		widx = 8'h00;
		ridx = 8'h00;
		rd = 32'h0000_0000;
		clr_mask = '0;
		next_state = state;
		// capture write address and data in either order
		if (s_axi_awvalid && state.awready) begin
			next_state.aw_held = 1'b1;
			next_state.aw_addr = s_axi_awaddr;
			next_state.awready = 1'b0;
		end
		if (s_axi_wvalid && state.wready) begin
			next_state.w_held = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
			next_state.wready = 1'b0;
		end
		// perform the write once both halves are held
		if (state.aw_held && state.w_held && !state.bvalid) begin
			aw_ok = 1'b1;
			widx = rxetg_index(state.aw_addr);
			next_state.aw_held = 1'b0;
			next_state.w_held = 1'b0;
			next_state.bvalid = 1'b1;
			next_state.bresp = rxetg_mapped(widx) ? RXETG_RESP_OKAY : RXETG_RESP_SLVERR;
		end
		if (aw_ok && state.w_strb[0]) begin
			unique case (widx)
				RXETG_IDX_MODE_ONE: begin
					next_state.buffer_transfer_trigger_mode = state.w_data[1:0];
				end
				RXETG_IDX_MODE_TWO: begin
					next_state.status_crc_error_trigger_mode = state.w_data[7:6];
					next_state.parity_error_trigger_mode = state.w_data[5:4];
					next_state.validity_error_trigger_mode = state.w_data[3:2];
					next_state.biphase_error_trigger_mode = state.w_data[1:0];
				end
				RXETG_IDX_MODE_THREE: begin
					next_state.output_slip_trigger_mode = state.w_data[1:0];
				end
				RXETG_IDX_GPO_SEL: begin
					next_state.output_one_source_select = state.w_data[3:0];
				end
				RXETG_IDX_MASK: begin
					next_state.mask = state.w_data[RXETG_NUM_EV-1:0];
				end
				default: begin
				end
			endcase
		end
		// response handshakes reopen the channels
		if (state.bvalid && s_axi_bready) begin
			next_state.bvalid = 1'b0;
			next_state.awready = 1'b1;
			next_state.wready = 1'b1;
		end
		if (state.rvalid && s_axi_rready) begin
			next_state.rvalid = 1'b0;
			next_state.arready = 1'b1;
		end
		// read: one cycle after address acceptance
		if (s_axi_arvalid && state.arready) begin
			ridx = rxetg_index(s_axi_araddr);
			unique case (ridx)
				RXETG_IDX_MODE_ONE: rd = {30'h0, state.buffer_transfer_trigger_mode};
				RXETG_IDX_MODE_TWO: rd = {24'h0, state.status_crc_error_trigger_mode,
					state.parity_error_trigger_mode, state.validity_error_trigger_mode,
					state.biphase_error_trigger_mode};
				RXETG_IDX_MODE_THREE: rd = {30'h0, state.output_slip_trigger_mode};
				RXETG_IDX_GPO_SEL: rd = {28'h0, state.output_one_source_select};
				RXETG_IDX_STATUS: begin
					rd = {26'h0, state.status};
					clr_mask = state.status;
				end
				RXETG_IDX_MASK: rd = {26'h0, state.mask};
				default: rd = 32'h0000_0000;
			endcase
			next_state.arready = 1'b0;
			next_state.rvalid = 1'b1;
			next_state.rdata = rd;
			next_state.rresp = rxetg_mapped(ridx) ? RXETG_RESP_OKAY : RXETG_RESP_SLVERR;
		end
		// sticky status: a new request wins over the read clear
		next_status = (state.status & ~clr_mask) | trig.request;
		next_state.status = next_status;
		next_state.irq = |(next_status & state.mask);
		// output one source
		unique case (state.output_one_source_select)
			RXETG_SEL_LOW: next_state.pin = 1'b0;
			RXETG_SEL_HIGH: next_state.pin = 1'b1;
			RXETG_SEL_SRC: next_state.pin = ~src_irq;
			RXETG_SEL_TX: next_state.pin = ~tx_irq;
			RXETG_SEL_RX: next_state.pin = ~state.irq;
			default: next_state.pin = 1'b0; // codes of other functions
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= '0;
			state.awready <= 1'b1;
			state.wready <= 1'b1;
			state.arready <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	assign s_axi_awready = state.awready;
	assign s_axi_wready = state.wready;
	assign s_axi_bvalid = state.bvalid;
	assign s_axi_bresp = state.bresp;
	assign s_axi_arready = state.arready;
	assign s_axi_rvalid = state.rvalid;
	assign s_axi_rdata = state.rdata;
	assign s_axi_rresp = state.rresp;
	assign rx_irq = state.irq;
	assign general_output_pin_one = state.pin;

	////////////////////////////////////////////////////////////////////////
	// assertions
	a_rise_sets_status: assert property (@(posedge aclk) disable iff (!aresetn)
		(state.buffer_transfer_trigger_mode == RXETG_MODE_RISE && rx_event_flag[0] &&
		!$past(rx_event_flag[0]) && $past(aresetn)) |=> state.status[0])
		else $error("rising edge did not set status");
	a_fall_sets_status: assert property (@(posedge aclk) disable iff (!aresetn)
		(state.biphase_error_trigger_mode == RXETG_MODE_FALL && !rx_event_flag[4] &&
		$past(rx_event_flag[4]) && $past(aresetn)) |=> state.status[4])
		else $error("falling edge did not set status");
	a_reserved_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		(state.output_slip_trigger_mode == RXETG_MODE_RSVD) |-> !trig.request[5])
		else $error("reserved mode raised a request");
	a_pin_forced_low: assert property (@(posedge aclk) disable iff (!aresetn)
		(state.output_one_source_select == RXETG_SEL_LOW)[*2] |-> !general_output_pin_one)
		else $error("forced low not low");
	a_pin_forced_high: assert property (@(posedge aclk) disable iff (!aresetn)
		(state.output_one_source_select == RXETG_SEL_HIGH)[*2] |-> general_output_pin_one)
		else $error("forced high not high");
	a_pin_src_inv: assert property (@(posedge aclk) disable iff (!aresetn)
		(state.output_one_source_select == RXETG_SEL_SRC) ##1
		(state.output_one_source_select == RXETG_SEL_SRC) |->
		general_output_pin_one == !$past(src_irq))
		else $error("converter interrupt not inverted");
	a_pin_tx_inv: assert property (@(posedge aclk) disable iff (!aresetn)
		(state.output_one_source_select == RXETG_SEL_TX) ##1
		(state.output_one_source_select == RXETG_SEL_TX) |->
		general_output_pin_one == !$past(tx_irq))
		else $error("transmitter interrupt not inverted");
	a_pin_rx_inv: assert property (@(posedge aclk) disable iff (!aresetn)
		(state.output_one_source_select == RXETG_SEL_RX) ##1
		(state.output_one_source_select == RXETG_SEL_RX) |->
		general_output_pin_one == !$past(rx_irq))
		else $error("receiver interrupt not inverted");
	a_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn)
		rx_irq == |($past(next_status) & $past(state.mask)))
		else $error("interrupt level mismatch");
	a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready &&
		rxetg_index(s_axi_araddr) == RXETG_IDX_MODE_THREE) |=> s_axi_rdata[31:2] == 30'h0)
		else $error("slip mode upper bits not zero");
	c_rise_event: cover property (@(posedge aclk) disable iff (!aresetn) trig.request[0]);
	c_level_mode: cover property (@(posedge aclk) disable iff (!aresetn)
		state.parity_error_trigger_mode == RXETG_MODE_LEVEL && trig.request[2]);
	c_rx_on_pin: cover property (@(posedge aclk) disable iff (!aresetn)
		state.output_one_source_select == RXETG_SEL_RX && !general_output_pin_one);
	c_irq_high: cover property (@(posedge aclk) disable iff (!aresetn) rx_irq);
endmodule : rxetg_top

// ### rtl/rxetg_pkg.sv
// rxetg_pkg: register map, field layouts and encodings of the receiver event trigger block
package rxetg_pkg;
	// register word indices; the bus byte address is four times the index
	localparam logic [7:0] RXETG_IDX_MODE_TWO = 8'h19;
	localparam logic [7:0] RXETG_IDX_MODE_THREE = 8'h1A;
	localparam logic [7:0] RXETG_IDX_GPO_SEL = 8'h1B;
	localparam logic [7:0] RXETG_IDX_MODE_ONE = 8'h20;
	localparam logic [7:0] RXETG_IDX_STATUS = 8'h21;
	localparam logic [7:0] RXETG_IDX_MASK = 8'h22;
	localparam int RXETG_ADDR_W = 10;
	localparam int RXETG_NUM_EV = 6;
	// event bit positions in status and mask
	localparam int RXETG_EV_BUF = 0;
	localparam int RXETG_EV_CRC = 1;
	localparam int RXETG_EV_PAR = 2;
	localparam int RXETG_EV_VAL = 3;
	localparam int RXETG_EV_BIP = 4;
	localparam int RXETG_EV_SLIP = 5;
	// trigger mode encodings
	localparam logic [1:0] RXETG_MODE_RISE = 2'h0;
	localparam logic [1:0] RXETG_MODE_FALL = 2'h1;
	localparam logic [1:0] RXETG_MODE_LEVEL = 2'h2;
	localparam logic [1:0] RXETG_MODE_RSVD = 2'h3;
	// output select encodings
	localparam logic [3:0] RXETG_SEL_LOW = 4'h0;
	localparam logic [3:0] RXETG_SEL_HIGH = 4'h1;
	localparam logic [3:0] RXETG_SEL_SRC = 4'h2;
	localparam logic [3:0] RXETG_SEL_TX = 4'h3;
	localparam logic [3:0] RXETG_SEL_RX = 4'h4;
	// reset values
	localparam logic [1:0] RXETG_MODE_RST = 2'h0;
	localparam logic [3:0] RXETG_SEL_RST = 4'h0;
	localparam logic [5:0] RXETG_MASK_RST = 6'h00;
	localparam logic [1:0] RXETG_RESP_OKAY = 2'h0;
	localparam logic [1:0] RXETG_RESP_SLVERR = 2'h2;
endpackage : rxetg_pkg

// ### rtl/rxetg_trig_if.sv
// rxetg_trig_if: carries event flags, trigger modes and requests between the top and the detector
interface rxetg_trig_if #(parameter int NUM_EV = 6);
	logic [NUM_EV-1:0] flag;
	logic [2*NUM_EV-1:0] mode;
	logic [NUM_EV-1:0] request;
	modport top (output flag, output mode, input request);
	modport det (input flag, input mode, output request);
endinterface : rxetg_trig_if

// ### rtl/rxetg_detect.sv
// rxetg_detect: per-event edge or level trigger detection
module rxetg_detect
	import rxetg_pkg::*;
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	rxetg_trig_if.det trig // flags in, requests out
);
	typedef struct packed {
		logic [RXETG_NUM_EV-1:0] prev;
	} rxetg_det_state_t;
	rxetg_det_state_t state;
	rxetg_det_state_t next_state;
	logic [RXETG_NUM_EV-1:0] req;

	////////////////////////////////////////////////////////////////////////
	// one request term per event, chosen by its mode field
	for (genvar i = 0; i < RXETG_NUM_EV; i++) begin : g_ev
		always_comb begin
			unique case (trig.mode[2*i +: 2])
				RXETG_MODE_RISE: req[i] = trig.flag[i] & ~state.prev[i];
				RXETG_MODE_FALL: req[i] = ~trig.flag[i] & state.prev[i];
				RXETG_MODE_LEVEL: req[i] = trig.flag[i];
				RXETG_MODE_RSVD: req[i] = 1'b0; // reserved code raises nothing
			endcase
		end
	end
	assign trig.request = req;

	////////////////////////////////////////////////////////////////////////
	// flag history
	always_comb begin
		next_state = state;
		next_state.prev = trig.flag;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
endmodule : rxetg_detect

// ### sim/tb_top.sv
// tb_top: self-checking bench for the receiver event trigger block
module tb_top
	import rxetg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic src_irq, tx_irq, rx_irq, general_output_pin_one;
	logic [RXETG_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [RXETG_NUM_EV-1:0] rx_event_flag;
	int mismatches, comparisons;

	rxetg_top i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_event_flag(rx_event_flag),
		.src_irq(src_irq), .tx_irq(tx_irq), .rx_irq(rx_irq),
		.general_output_pin_one(general_output_pin_one));

	////////////////////////////////////////////////////////////////////////////////
	// clock, 4 ns period
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// watchdog cuts a hung handshake short
	initial begin
		#40000;
		mismatches++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////////
	// shared helpers
	function automatic logic [RXETG_ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		return {idx, 2'b00};
	endfunction : byte_addr

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic cycles(input int n);
		repeat (n) @(posedge aclk);
	endtask : cycles

	// one write: address and data offered together, each released when taken
	task automatic reg_write(input logic [7:0] idx, input logic [31:0] data,
		input logic [1:0] exp_resp);
		logic waiting;
		@(posedge aclk);
		s_axi_awaddr <= byte_addr(idx);
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= data;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		waiting = 1'b1;
		while (waiting) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				waiting = 1'b0;
				check({30'h0, s_axi_bresp}, {30'h0, exp_resp});
			end
		end
	endtask : reg_write

	// one read, data and response compared at the handshake edge
	task automatic reg_read(input logic [7:0] idx, input logic [31:0] exp_data,
		input logic [1:0] exp_resp);
		logic waiting;
		@(posedge aclk);
		s_axi_araddr <= byte_addr(idx);
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		waiting = 1'b1;
		while (waiting) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				waiting = 1'b0;
				check(s_axi_rdata, exp_data);
				check({30'h0, s_axi_rresp}, {30'h0, exp_resp});
			end
		end
	endtask : reg_read

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic test_reset_values();
		logic [7:0] idx [6] = '{RXETG_IDX_MODE_TWO, RXETG_IDX_MODE_THREE, RXETG_IDX_GPO_SEL,
			RXETG_IDX_MODE_ONE, RXETG_IDX_STATUS, RXETG_IDX_MASK};
		foreach (idx[i]) reg_read(idx[i], 32'h0, RXETG_RESP_OKAY);
		check({31'h0, general_output_pin_one}, 32'h0);
		reg_read(8'hFF, 32'h0, RXETG_RESP_SLVERR);
		reg_write(8'hFF, 32'hFF, RXETG_RESP_SLVERR);
	endtask : test_reset_values

	// unused upper bits read zero, full mode byte holds all four fields; no reserved code
	task automatic test_reg_fields();
		reg_write(RXETG_IDX_MODE_TWO, 32'hAA, RXETG_RESP_OKAY);
		reg_read(RXETG_IDX_MODE_TWO, 32'hAA, RXETG_RESP_OKAY);
		reg_write(RXETG_IDX_MODE_THREE, 32'hFE, RXETG_RESP_OKAY);
		reg_read(RXETG_IDX_MODE_THREE, 32'h02, RXETG_RESP_OKAY);
		reg_write(RXETG_IDX_GPO_SEL, 32'hF4, RXETG_RESP_OKAY);
		reg_read(RXETG_IDX_GPO_SEL, 32'h04, RXETG_RESP_OKAY);
		reg_write(RXETG_IDX_MODE_THREE, 32'h00, RXETG_RESP_OKAY);
	endtask : test_reg_fields

	// both fixed states and the converter and transmitter sources, with the source toggled while the code is held
	task automatic test_pin_select();
		logic exp;
		for (int code = 0; code < 4; code++) begin
			reg_write(RXETG_IDX_GPO_SEL, code, RXETG_RESP_OKAY);
			for (int s = 0; s < 2; s++) begin
				@(posedge aclk);
				src_irq <= s[0];
				tx_irq <= ~s[0];
				cycles(4);
				exp = (code == 0) ? 1'b0 : (code == 1) ? 1'b1 : (code == 2) ? ~s[0] : s[0];
				check({31'h0, general_output_pin_one}, {31'h0, exp});
			end
		end
	endtask : test_pin_select

	// crc rising, parity falling, validity level, biphase falling, slip falling
	task automatic test_events();
		reg_write(RXETG_IDX_MASK, 32'h3F, RXETG_RESP_OKAY);
		reg_write(RXETG_IDX_MODE_TWO, 32'h19, RXETG_RESP_OKAY);
		reg_write(RXETG_IDX_MODE_THREE, 32'h01, RXETG_RESP_OKAY);
		reg_write(RXETG_IDX_GPO_SEL, RXETG_SEL_RX, RXETG_RESP_OKAY);
		cycles(4);
		check({31'h0, general_output_pin_one}, 32'h1);
		@(posedge aclk);
		rx_event_flag <= 6'h3F;
		cycles(4);
		check({31'h0, rx_irq}, 32'h1);
		check({31'h0, general_output_pin_one}, 32'h0);
		reg_read(RXETG_IDX_STATUS, 32'h0B, RXETG_RESP_OKAY);
		@(posedge aclk);
		rx_event_flag <= 6'h00;
		cycles(4);
		reg_read(RXETG_IDX_STATUS, 32'h3C, RXETG_RESP_OKAY);
		reg_read(RXETG_IDX_STATUS, 32'h00, RXETG_RESP_OKAY);
		cycles(4);
		check({31'h0, rx_irq}, 32'h0);
		check({31'h0, general_output_pin_one}, 32'h1);
		// masked event still latches status but keeps the interrupt low
		reg_write(RXETG_IDX_MASK, 32'h3E, RXETG_RESP_OKAY);
		@(posedge aclk);
		rx_event_flag <= 6'h01;
		cycles(4);
		check({31'h0, rx_irq}, 32'h0);
		reg_read(RXETG_IDX_STATUS, 32'h01, RXETG_RESP_OKAY);
	endtask : test_events

	////////////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic report_and_stop();
		if (mismatches == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	// main sequence: reset for three cycles, then the scenarios
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		rx_event_flag = 6'h00;
		src_irq = 1'b0;
		tx_irq = 1'b0;
		mismatches = 0;
		comparisons = 0;
		cycles(3);
		aresetn <= 1'b1;
		test_reset_values();
		test_reg_fields();
		test_pin_select();
		test_events();
		report_and_stop();
	end
endmodule : tb_top
